// ===== include/pptr_pkg.sv
`default_nettype none
package pptr_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int HALF_W = 16;
	localparam int TS_W   = 32;
	localparam int CORR_W = 64;
	localparam int FRAC_W = 16;
	localparam int IDX_W  = 12;
	localparam int SLOTS  = 3;

	// printed offsets are word indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_RX_DELAY     = 12'hc00;
	localparam logic [IDX_W-1:0] IDX_TX_DELAY     = 12'hc02;
	localparam logic [IDX_W-1:0] IDX_ASYMMETRY    = 12'hc04;
	localparam logic [IDX_W-1:0] IDX_DREQ_HIGH    = 12'hc08;
	localparam logic [IDX_W-1:0] IDX_DREQ_LOW     = 12'hc0a;
	localparam logic [IDX_W-1:0] IDX_SYNC_HIGH    = 12'hc0c;
	localparam logic [IDX_W-1:0] IDX_SYNC_LOW     = 12'hc0e;
	localparam logic [IDX_W-1:0] IDX_PRESP_HIGH   = 12'hc10;
	localparam logic [IDX_W-1:0] IDX_PRESP_LOW    = 12'hc12;
	localparam logic [IDX_W-1:0] IDX_READY_FLAGS  = 12'hc14;
	localparam logic [IDX_W-1:0] IDX_IRQ_ALLOW    = 12'hc16;
	localparam logic [IDX_W-1:0] IDX_PORT_SUMMARY = 12'hc1c;

	localparam logic [HALF_W-1:0] RST_RX_DELAY  = 16'h019f;
	localparam logic [HALF_W-1:0] RST_TX_DELAY  = 16'h002d;
	localparam logic [HALF_W-1:0] RST_ASYMMETRY = 16'h0000;
	localparam logic [HALF_W-1:0] RST_FLAGS     = 16'h0000;
	localparam logic [TS_W-1:0]   RST_STAMP     = 32'h0000_0000;

	localparam int ASYM_SIGN_BIT = 15;
	localparam int ASYM_MAG_W    = 15;
	localparam int FLAG_SYNC     = 15;
	localparam int FLAG_DREQ     = 14;
	localparam int FLAG_PRESP    = 13;
	localparam logic [HALF_W-1:0] FLAG_MASK = 16'he000;
	localparam int SUM_ANY_BIT   = 0;
	localparam int SUM_IRQ_BIT   = 1;

	// stamp slot numbers
	localparam int SLOT_DREQ  = 0;
	localparam int SLOT_SYNC  = 1;
	localparam int SLOT_PRESP = 2;

	localparam logic [3:0] MSG_SYNC        = 4'h0;
	localparam logic [3:0] MSG_DELAY_REQ   = 4'h1;
	localparam logic [3:0] MSG_PDELAY_REQ  = 4'h2;
	localparam logic [3:0] MSG_PDELAY_RESP = 4'h3;

	typedef enum logic [3:0] {
		REG_NONE      = 4'h0,
		REG_RX_DELAY  = 4'h1,
		REG_TX_DELAY  = 4'h2,
		REG_ASYMMETRY = 4'h3,
		REG_DREQ_HI   = 4'h4,
		REG_DREQ_LO   = 4'h5,
		REG_SYNC_HI   = 4'h6,
		REG_SYNC_LO   = 4'h7,
		REG_PRESP_HI  = 4'h8,
		REG_PRESP_LO  = 4'h9,
		REG_FLAGS     = 4'ha,
		REG_ALLOW     = 4'hb,
		REG_SUMMARY   = 4'hc
	} pptr_reg_e;

	typedef struct packed {
		logic             valid;
		logic [3:0]       msg_type;
		logic [TS_W-1:0]  stamp;
	} pptr_egress_s;

	typedef struct packed {
		logic              valid;
		logic              ingress;
		logic [3:0]        msg_type;
		logic [CORR_W-1:0] corr;
	} pptr_corr_s;
endpackage
`default_nettype wire

// ===== core/pptr_stamp_slot.sv
`timescale 1ns/10ps
`default_nettype none
module pptr_stamp_slot #(
	parameter int TS_W = 32
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            capture,
	input  wire logic [TS_W-1:0] stamp_in,
	output logic      [TS_W-1:0] stamp_q
);
	// one 32-bit flop set loaded whole per frame; halves are read separately, so a capture between the two reads mixes frames
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stamp_q <= '0;
		end
		else if (capture)
		begin
			stamp_q <= stamp_in;
		end
	end
endmodule
`default_nettype wire

// ===== core/pptr_corr_adjust.sv
`timescale 1ns/10ps
`default_nettype none
module pptr_corr_adjust #(
	parameter int CORR_W = 64,
	parameter int FRAC_W = 16
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              asymmetry_negative_flag,
	input  wire logic [14:0]       asymmetry_magnitude_ns,
	input  wire pptr_pkg::pptr_corr_s corr_in,
	output pptr_pkg::pptr_corr_s   corr_q
);
	logic [CORR_W-1:0] scaled;
	logic [CORR_W-1:0] delta;
	logic              add_it;
	logic              sub_it;

	// correction field counts ns in units of 2^-FRAC_W
	assign scaled = CORR_W'(asymmetry_magnitude_ns) << FRAC_W;
	assign delta  = asymmetry_negative_flag ? (~scaled + 1'b1) : scaled;
	assign add_it = corr_in.ingress &&
		(corr_in.msg_type == pptr_pkg::MSG_SYNC ||
		 corr_in.msg_type == pptr_pkg::MSG_PDELAY_RESP);
	assign sub_it = !corr_in.ingress &&
		(corr_in.msg_type == pptr_pkg::MSG_DELAY_REQ ||
		 corr_in.msg_type == pptr_pkg::MSG_PDELAY_REQ);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			corr_q <= '0;
		end
		else
		begin
			corr_q.valid    <= corr_in.valid;
			corr_q.ingress  <= corr_in.ingress;
			corr_q.msg_type <= corr_in.msg_type;
			if (add_it)
			begin
				corr_q.corr <= corr_in.corr + delta;
			end
			else if (sub_it)
			begin
				corr_q.corr <= corr_in.corr - delta;
			end
			else
			begin
				corr_q.corr <= corr_in.corr;
			end
		end
	end
endmodule
`default_nettype wire

// ===== core/pptr_top.sv
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// - a 16-bit read/write receive delay in ns, reset to 415.
// - a 16-bit read/write transmit delay in ns, reset to 45.
// - bit 15 of the asymmetry register is its sign, one meaning negative, reset zero.
// - the signed 15-bit asymmetry is added to the correction of ingress sync and peer-delay responses.
// - the signed asymmetry is subtracted from the correction of egress delay and peer-delay requests.
// - a read-only word shows bits 31:16 of the last request egress stamp, reset zero.
// - the next word shows bits 15:0 of that request stamp, read-only.
// - a read-only word shows bits 31:16 of the sync egress stamp, reset zero.
// - a read-only word shows bits 15:0 of the sync egress stamp.
// - a read-only word shows bits 31:16 of the peer-delay response egress stamp, reset zero.
// - a read-only word shows bits 15:0 of the peer-delay response egress stamp.
// - write-one-to-clear ready flags at bits 15, 14, 13 are set per new stamp and ORed to a port bit.
// - matching read/write allow bits gate each flag onto the port interrupt.
module pptr_top #(
	parameter int CORR_W = pptr_pkg::CORR_W,
	parameter int FRAC_W = pptr_pkg::FRAC_W
) (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [pptr_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [pptr_pkg::DATA_W-1:0]  pwdata,
	input  wire logic [3:0]                   pstrb,
	output logic                              pready,
	output logic      [pptr_pkg::DATA_W-1:0]  prdata,
	output logic                              pslverr,
	input  wire pptr_pkg::pptr_egress_s       egress,
	input  wire pptr_pkg::pptr_corr_s         corr_in,
	output pptr_pkg::pptr_corr_s              corr_out,
	output logic      [pptr_pkg::HALF_W-1:0]  port_receive_delay_ns,
	output logic      [pptr_pkg::HALF_W-1:0]  port_transmit_delay_ns,
	output logic                              port_ptp_status,
	output logic                              irq
);
	localparam int HW = pptr_pkg::HALF_W;

	logic [HW-1:0]               rx_delay_q;
	logic [HW-1:0]               tx_delay_q;
	logic [HW-1:0]               asym_q;
	logic [HW-1:0]               flags_q;
	logic [HW-1:0]               allow_q;
	logic [HW-1:0]               rx_delay_d;
	logic [HW-1:0]               tx_delay_d;
	logic [HW-1:0]               asym_d;
	logic [HW-1:0]               flags_d;
	logic [HW-1:0]               allow_d;
	logic [pptr_pkg::DATA_W-1:0] prdata_d;
	logic                        pslverr_d;
	logic [HW-1:0]               flag_set;
	logic [HW-1:0]               flag_clr;
	logic [pptr_pkg::SLOTS-1:0]  capture;
	logic [pptr_pkg::TS_W-1:0]   stamp [pptr_pkg::SLOTS];
	logic [pptr_pkg::DATA_W-1:0] prdata_q;
	logic                        pslverr_q;
	logic                        setup;
	logic                        access;
	logic                        wr_en;
	logic [HW-1:0]               wr_mask;
	logic [HW-1:0]               wr_half;
	logic                        asymmetry_negative_flag;
	logic [14:0]                 asymmetry_magnitude_ns;
	logic                        any_flag;
	pptr_pkg::pptr_reg_e         sel;

	// index from byte address; misaligned or out of range maps nowhere
	function automatic pptr_pkg::pptr_reg_e reg_decode(
		input logic [pptr_pkg::ADDR_W-1:0] addr
	);
		logic [pptr_pkg::IDX_W-1:0] idx;
		pptr_pkg::pptr_reg_e        r;
		idx = addr[13:2];
		r = pptr_pkg::REG_NONE;
		if (addr[1:0] == 2'b00 && addr[15:14] == 2'b00)
		begin
			unique case (idx)
				pptr_pkg::IDX_RX_DELAY:     r = pptr_pkg::REG_RX_DELAY;
				pptr_pkg::IDX_TX_DELAY:     r = pptr_pkg::REG_TX_DELAY;
				pptr_pkg::IDX_ASYMMETRY:    r = pptr_pkg::REG_ASYMMETRY;
				pptr_pkg::IDX_DREQ_HIGH:    r = pptr_pkg::REG_DREQ_HI;
				pptr_pkg::IDX_DREQ_LOW:     r = pptr_pkg::REG_DREQ_LO;
				pptr_pkg::IDX_SYNC_HIGH:    r = pptr_pkg::REG_SYNC_HI;
				pptr_pkg::IDX_SYNC_LOW:     r = pptr_pkg::REG_SYNC_LO;
				pptr_pkg::IDX_PRESP_HIGH:   r = pptr_pkg::REG_PRESP_HI;
				pptr_pkg::IDX_PRESP_LOW:    r = pptr_pkg::REG_PRESP_LO;
				pptr_pkg::IDX_READY_FLAGS:  r = pptr_pkg::REG_FLAGS;
				pptr_pkg::IDX_IRQ_ALLOW:    r = pptr_pkg::REG_ALLOW;
				pptr_pkg::IDX_PORT_SUMMARY: r = pptr_pkg::REG_SUMMARY;
				default:                    r = pptr_pkg::REG_NONE;
			endcase
		end
		return r;
	endfunction

	// byte enables of the two low lanes as a 16-bit mask
	function automatic logic [HW-1:0] lane_mask(
		input logic [3:0] strb
	);
		return {{8{strb[1]}}, {8{strb[0]}}};
	endfunction

	// new value of a plain read/write half word under byte enables
	function automatic logic [HW-1:0] merge(
		input logic [HW-1:0] old,
		input logic [HW-1:0] data,
		input logic [HW-1:0] mask
	);
		return (old & ~mask) | (data & mask);
	endfunction

	assign sel     = reg_decode(paddr);
	assign setup   = psel && !penable;
	assign access  = psel && penable;
	assign pready  = 1'b1;
	assign wr_en   = access && pwrite;
	assign wr_mask = lane_mask(pstrb);
	assign wr_half = pwdata[HW-1:0];
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q && access;

	// next values of the software-written words under byte enables
	always_comb
	begin
		rx_delay_d = rx_delay_q;
		tx_delay_d = tx_delay_q;
		asym_d     = asym_q;
		allow_d    = allow_q;
		if (wr_en)
		begin
			case (sel)
				pptr_pkg::REG_RX_DELAY:
					rx_delay_d = merge(rx_delay_q, wr_half, wr_mask);
				pptr_pkg::REG_TX_DELAY:
					tx_delay_d = merge(tx_delay_q, wr_half, wr_mask);
				pptr_pkg::REG_ASYMMETRY:
					asym_d = merge(asym_q, wr_half, wr_mask);
				pptr_pkg::REG_ALLOW:
					allow_d = merge(allow_q, wr_half, wr_mask) & pptr_pkg::FLAG_MASK;
				default:
					allow_d = allow_q;
			endcase
		end
	end

	// software-programmed delays
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_delay_q <= pptr_pkg::RST_RX_DELAY;
		end
		else
		begin
			rx_delay_q <= rx_delay_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_delay_q <= pptr_pkg::RST_TX_DELAY;
		end
		else
		begin
			tx_delay_q <= tx_delay_d;
		end
	end

	assign port_receive_delay_ns  = rx_delay_q;
	assign port_transmit_delay_ns = tx_delay_q;

	// sign and magnitude held as written, no two's complement conversion
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			asym_q <= pptr_pkg::RST_ASYMMETRY;
		end
		else
		begin
			asym_q <= asym_d;
		end
	end

	assign asymmetry_negative_flag = asym_q[pptr_pkg::ASYM_SIGN_BIT];
	assign asymmetry_magnitude_ns  = asym_q[pptr_pkg::ASYM_MAG_W-1:0];

	// correction path: one cycle of latency, values taken from live registers
	pptr_corr_adjust #(
		.CORR_W (CORR_W),
		.FRAC_W (FRAC_W)
	) u_corr (
		.pclk                    (pclk),
		.presetn                 (presetn),
		.asymmetry_negative_flag (asymmetry_negative_flag),
		.asymmetry_magnitude_ns  (asymmetry_magnitude_ns),
		.corr_in                 (corr_in),
		.corr_q                  (corr_out)
	);

	// frame type to stamp slot; both request kinds share one slot
	always_comb
	begin
		capture = '0;
		if (egress.valid)
		begin
			unique case (egress.msg_type)
				pptr_pkg::MSG_SYNC:
					capture[pptr_pkg::SLOT_SYNC] = 1'b1;
				pptr_pkg::MSG_DELAY_REQ,
				pptr_pkg::MSG_PDELAY_REQ:
					capture[pptr_pkg::SLOT_DREQ] = 1'b1;
				pptr_pkg::MSG_PDELAY_RESP:
					capture[pptr_pkg::SLOT_PRESP] = 1'b1;
				default:
					capture = '0;
			endcase
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < pptr_pkg::SLOTS; gi++)
		begin : g_slot
			pptr_stamp_slot #(
				.TS_W (pptr_pkg::TS_W)
			) u_slot (
				.pclk     (pclk),
				.presetn  (presetn),
				.capture  (capture[gi]),
				.stamp_in (egress.stamp),
				.stamp_q  (stamp[gi])
			);
		end
	endgenerate

	// ready flags: set wins over a same-cycle write-one clear
	always_comb
	begin
		flag_set = '0;
		flag_set[pptr_pkg::FLAG_SYNC]  = capture[pptr_pkg::SLOT_SYNC];
		flag_set[pptr_pkg::FLAG_DREQ]  = capture[pptr_pkg::SLOT_DREQ];
		flag_set[pptr_pkg::FLAG_PRESP] = capture[pptr_pkg::SLOT_PRESP];
	end

	assign flag_clr = (wr_en && sel == pptr_pkg::REG_FLAGS) ?
		(wr_half & wr_mask & pptr_pkg::FLAG_MASK) : '0;
	assign flags_d  = ((flags_q & ~flag_clr) | flag_set) & pptr_pkg::FLAG_MASK;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flags_q <= pptr_pkg::RST_FLAGS;
		end
		else
		begin
			flags_q <= flags_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			allow_q <= pptr_pkg::RST_FLAGS;
		end
		else
		begin
			allow_q <= allow_d;
		end
	end

	// port-level status ignores the allow bits; only irq honours them
	assign any_flag        = |flags_q;
	assign port_ptp_status = any_flag;
	assign irq             = |(flags_q & allow_q);

	// read word of the addressed register; reserved bits and unmapped words read zero
	always_comb
	begin
		prdata_d = '0;
		unique case (sel)
			pptr_pkg::REG_RX_DELAY:
				prdata_d[HW-1:0] = rx_delay_q;
			pptr_pkg::REG_TX_DELAY:
				prdata_d[HW-1:0] = tx_delay_q;
			pptr_pkg::REG_ASYMMETRY:
				prdata_d[HW-1:0] = asym_q;
			pptr_pkg::REG_DREQ_HI:
				prdata_d[HW-1:0] = stamp[pptr_pkg::SLOT_DREQ][31:16];
			pptr_pkg::REG_DREQ_LO:
				prdata_d[HW-1:0] = stamp[pptr_pkg::SLOT_DREQ][15:0];
			pptr_pkg::REG_SYNC_HI:
				prdata_d[HW-1:0] = stamp[pptr_pkg::SLOT_SYNC][31:16];
			pptr_pkg::REG_SYNC_LO:
				prdata_d[HW-1:0] = stamp[pptr_pkg::SLOT_SYNC][15:0];
			pptr_pkg::REG_PRESP_HI:
				prdata_d[HW-1:0] = stamp[pptr_pkg::SLOT_PRESP][31:16];
			pptr_pkg::REG_PRESP_LO:
				prdata_d[HW-1:0] = stamp[pptr_pkg::SLOT_PRESP][15:0];
			pptr_pkg::REG_FLAGS:
				prdata_d[HW-1:0] = flags_q;
			pptr_pkg::REG_ALLOW:
				prdata_d[HW-1:0] = allow_q;
			pptr_pkg::REG_SUMMARY:
			begin
				prdata_d[pptr_pkg::SUM_ANY_BIT] = any_flag;
				prdata_d[pptr_pkg::SUM_IRQ_BIT] = irq;
			end
			pptr_pkg::REG_NONE:
				prdata_d = '0;
		endcase
	end

	// read data is taken in the setup cycle so the access needs no wait
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q <= '0;
		end
		else if (setup && !pwrite)
		begin
			prdata_q <= prdata_d;
		end
	end

	// unmapped addresses answer with an error; writes to read-only words are dropped quietly
	assign pslverr_d = (sel == pptr_pkg::REG_NONE);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pslverr_q <= 1'b0;
		end
		else if (setup)
		begin
			pslverr_q <= pslverr_d;
		end
	end
endmodule
`default_nettype wire

// ===== bench/pptr_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module pptr_monitor (
	input wire logic                        pclk,
	input wire logic                        presetn,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pwrite,
	input wire logic [pptr_pkg::ADDR_W-1:0] paddr,
	input wire logic [pptr_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0]                  pstrb,
	input wire logic                        pready,
	input wire logic [pptr_pkg::DATA_W-1:0] prdata,
	input wire pptr_pkg::pptr_egress_s      egress,
	input wire pptr_pkg::pptr_corr_s        corr_in,
	input wire pptr_pkg::pptr_corr_s        corr_out,
	input wire logic [pptr_pkg::HALF_W-1:0] port_receive_delay_ns,
	input wire logic [pptr_pkg::HALF_W-1:0] port_transmit_delay_ns,
	input wire logic                        port_ptp_status,
	input wire logic                        irq
);
	logic wr;
	assign wr = psel & penable & pwrite & pready & (pstrb[1:0] == 2'b11);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rx_rst; $rose(presetn) |-> port_receive_delay_ns == 16'h019f; endproperty
	a_rx_rst: assert property (p_rx_rst) else $error("rx delay not at reset value");
	property p_tx_rst; $rose(presetn) |-> port_transmit_delay_ns == 16'h002d; endproperty
	a_tx_rst: assert property (p_tx_rst) else $error("tx delay not at reset value");
	property p_rx_wr; wr && paddr == 16'h3000 |=> port_receive_delay_ns == $past(pwdata[15:0]); endproperty
	a_rx_wr: assert property (p_rx_wr) else $error("rx delay write lost");
	property p_tx_wr; wr && paddr == 16'h3008 |=> port_transmit_delay_ns == $past(pwdata[15:0]); endproperty
	a_tx_wr: assert property (p_tx_wr) else $error("tx delay write lost");
	property p_stat_set; egress.valid && egress.msg_type <= 4'h3 |=> port_ptp_status; endproperty
	a_stat_set: assert property (p_stat_set) else $error("status not set by stamp");
	property p_stat_hold; port_ptp_status && !(psel && penable && pwrite) |=> port_ptp_status; endproperty
	a_stat_hold: assert property (p_stat_hold) else $error("status dropped without write");
	property p_irq_gate; irq |-> port_ptp_status; endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without status");
	property p_corr_pass; !corr_in.ingress && corr_in.msg_type == 4'h0 |=> corr_out.corr == $past(corr_in.corr);
	endproperty
	a_corr_pass: assert property (p_corr_pass) else $error("egress sync correction altered");
	property p_corr_tag; corr_in.valid |=> corr_out.valid && corr_out.msg_type == $past(corr_in.msg_type);
	endproperty
	a_corr_tag: assert property (p_corr_tag) else $error("correction tag not carried");
	property p_rd_hi; psel && penable |-> prdata[31:16] == 16'h0000; endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("upper read half not zero");
endmodule
bind pptr_top pptr_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
	.egress(egress), .corr_in(corr_in), .corr_out(corr_out), .port_receive_delay_ns(port_receive_delay_ns),
	.port_transmit_delay_ns(port_transmit_delay_ns), .port_ptp_status(port_ptp_status), .irq(irq));
`default_nettype wire

// ===== bench/port_ptp_timestamp_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module port_ptp_timestamp_regs_tb_top;
	logic                   pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [15:0]            paddr = '0, rxd, txd;
	logic [31:0]            pwdata = '0, prdata, rd;
	logic [3:0]             pstrb = 4'hf;
	logic                   pready, pslverr, port_ptp_status, irq, err;
	pptr_pkg::pptr_egress_s egress = '0;
	pptr_pkg::pptr_corr_s   corr_in = '0, corr_out;
	int                     fail_count = 0, n_checks = 0;
	always #50 pclk = ~pclk;
	pptr_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.egress(egress), .corr_in(corr_in), .corr_out(corr_out), .port_receive_delay_ns(rxd),
		.port_transmit_delay_ns(txd), .port_ptp_status(port_ptp_status), .irq(irq));
	task automatic xfer(input logic w, input logic [11:0] i, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'b00, i, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input string n, input logic [11:0] i, input logic [31:0] e);
		xfer(1'b0, i, '0);
		`CHK(n, e, rd)
	endtask
	task automatic frame(input logic [3:0] t, input logic [31:0] s);
		@(posedge pclk);
		egress <= '{1'b1, t, s};
		@(posedge pclk);
		egress <= '0;
	endtask
	task automatic t_reset;
		rchk("rx", pptr_pkg::IDX_RX_DELAY, 32'h0000019f);
		rchk("tx", pptr_pkg::IDX_TX_DELAY, 32'h0000002d);
		rchk("asym", pptr_pkg::IDX_ASYMMETRY, '0);
		for (int k = 0; k < 6; k++)
			rchk("stamp", 12'hc08 + 12'(2 * k), '0);
		rchk("flags", pptr_pkg::IDX_READY_FLAGS, '0);
		rchk("allow", pptr_pkg::IDX_IRQ_ALLOW, '0);
	endtask
	task automatic t_rw;
		xfer(1'b1, pptr_pkg::IDX_RX_DELAY, 32'hffff_a5c3);
		rchk("rx", pptr_pkg::IDX_RX_DELAY, 32'h0000a5c3);
		`CHK("rx port", 16'ha5c3, rxd)
		xfer(1'b1, pptr_pkg::IDX_TX_DELAY, 32'h0000_5a3c);
		rchk("tx", pptr_pkg::IDX_TX_DELAY, 32'h00005a3c);
		`CHK("tx port", 16'h5a3c, txd)
		pstrb <= 4'h1;
		xfer(1'b1, pptr_pkg::IDX_TX_DELAY, 32'h0000_ffff);
		pstrb <= 4'hf;
		rchk("tx lane", pptr_pkg::IDX_TX_DELAY, 32'h00005aff);
		xfer(1'b0, 12'hc06, '0);
		`CHK("unmapped err", 1'b1, err)
	endtask
	task automatic t_stamps;
		frame(pptr_pkg::MSG_SYNC, 32'h1111_2222);
		frame(pptr_pkg::MSG_PDELAY_RESP, 32'h5555_6666);
		@(posedge pclk);
		egress <= '{1'b1, pptr_pkg::MSG_DELAY_REQ, 32'h3333_4444};
		@(posedge pclk);
		egress <= '{1'b1, pptr_pkg::MSG_PDELAY_REQ, 32'h7777_8888};
		@(posedge pclk);
		egress <= '0;
		frame(4'h7, 32'hdead_beef);
		xfer(1'b1, pptr_pkg::IDX_SYNC_HIGH, 32'h0000_ffff);
		rchk("req hi", pptr_pkg::IDX_DREQ_HIGH, 32'h00007777);
		rchk("req lo", pptr_pkg::IDX_DREQ_LOW, 32'h00008888);
		rchk("sync hi", pptr_pkg::IDX_SYNC_HIGH, 32'h00001111);
		rchk("sync lo", pptr_pkg::IDX_SYNC_LOW, 32'h00002222);
		rchk("resp hi", pptr_pkg::IDX_PRESP_HIGH, 32'h00005555);
		rchk("resp lo", pptr_pkg::IDX_PRESP_LOW, 32'h00006666);
	endtask
	task automatic t_irq;
		rchk("flags", pptr_pkg::IDX_READY_FLAGS, 32'h0000e000);
		`CHK("irq masked", 1'b0, irq)
		xfer(1'b1, pptr_pkg::IDX_IRQ_ALLOW, 32'h0000_ffff);
		rchk("allow", pptr_pkg::IDX_IRQ_ALLOW, 32'h0000e000);
		@(negedge pclk);
		`CHK("irq on", 1'b1, irq)
		xfer(1'b1, pptr_pkg::IDX_READY_FLAGS, 32'h0000_e000);
		xfer(1'b1, pptr_pkg::IDX_IRQ_ALLOW, 32'h0000_2000);
		@(negedge pclk);
		`CHK("status clr", 1'b0, port_ptp_status)
		frame(pptr_pkg::MSG_SYNC, 32'h0000_0001);
		@(negedge pclk);
		`CHK("sync masked", 2'b10, {port_ptp_status, irq})
		frame(pptr_pkg::MSG_PDELAY_RESP, 32'h0000_0002);
		@(negedge pclk);
		`CHK("resp irq", 1'b1, irq)
		xfer(1'b1, pptr_pkg::IDX_READY_FLAGS, 32'h0000_2000);
		@(negedge pclk);
		`CHK("w1c one", 2'b10, {port_ptp_status, irq})
		rchk("summary", pptr_pkg::IDX_PORT_SUMMARY, 32'h00000001);
	endtask
	task automatic t_corr;
		logic [63:0] d, c, e;
		for (int s = 0; s < 2; s++)
		begin
			xfer(1'b1, pptr_pkg::IDX_ASYMMETRY, {16'h0, s[0], 15'h7fff});
			rchk("asym", pptr_pkg::IDX_ASYMMETRY, {16'h0, s[0], 15'h7fff});
			d = s ? -(64'h7fff << 16) : (64'h7fff << 16);
			for (int k = 0; k < 8; k++)
			begin
				c = 64'h0000_1000_0000_0000 + 64'(k);
				e = (k[2] && (k[1:0] == 0 || k[1:0] == 3)) ? c + d :
					(!k[2] && (k[1:0] == 1 || k[1:0] == 2)) ? c - d : c;
				@(posedge pclk);
				corr_in <= '{1'b1, k[2], {2'b00, k[1:0]}, c};
				@(posedge pclk);
				@(negedge pclk);
				`CHK("corr", e, corr_out.corr)
			end
		end
	endtask
	task automatic end_of_test;
		if (fail_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_rw();
		t_stamps();
		t_irq();
		t_corr();
		end_of_test();
	end
	initial
	begin
		repeat (3000) @(posedge pclk);
		fail_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
